/* hw/enc_gate_pkg.sv */
package enc_gate_pkg;

  localparam int NUM_CH = 4;
  localparam int CNT_W  = 32;
  localparam int NUM_EV = 6;

  // Byte offsets of the register words
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK   = 8'h08;
  localparam logic [7:0] OFS_STRAPS = 8'h0c;
  localparam logic [7:0] OFS_COUNT0 = 8'h10;
  localparam logic [7:0] OFS_COUNT1 = 8'h14;
  localparam logic [7:0] OFS_COUNT2 = 8'h18;
  localparam logic [7:0] OFS_COUNT3 = 8'h1c;

  // Control word fields
  localparam int CTRL_ARM_BIT = 0;
  localparam int CTRL_CLR_LSB = 1;
  localparam logic CTRL_ARM_RST = 1'b0;

  // Event bits, shared by status and mask
  localparam int EV_LAS_ON    = 0;
  localparam int EV_LAS_OFF   = 1;
  localparam int EV_WRAP_LSB  = 2;
  localparam logic [NUM_EV-1:0] MASK_RST = 6'h00;

  // Strap readback fields
  localparam int SR_CONNECT = 0;
  localparam int SR_GATE    = 1;
  localparam int SR_SEL_LSB = 2;
  localparam int SR_FMT_LSB = 4;
  localparam int SR_DIR     = 8;
  localparam int SR_SRCA_LSB = 9;
  localparam int SR_SRCB_LSB = 13;
  localparam int SR_RATE_LSB = 17;

  // AHB-Lite encodings
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  // Sampling rate strap codes; any other code takes the processor clock
  localparam logic [2:0] RATE_2M5 = 3'h0;
  localparam logic [2:0] RATE_5M  = 3'h1;
  localparam logic [2:0] RATE_10M = 3'h2;
  localparam logic [2:0] RATE_20M = 3'h3;

  // Sample periods in ps; a sample tick never comes faster than the rate
  localparam int CLK_PERIOD_PS = 8000;
  localparam int PER_2M5_PS = 400000;
  localparam int PER_5M_PS  = 200000;
  localparam int PER_10M_PS = 100000;
  localparam int PER_20M_PS = 50000;
  localparam int DIV_W = 6;
  localparam logic [DIV_W-1:0] DIV_2M5 =
    DIV_W'((PER_2M5_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [DIV_W-1:0] DIV_5M =
    DIV_W'((PER_5M_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [DIV_W-1:0] DIV_10M =
    DIV_W'((PER_10M_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [DIV_W-1:0] DIV_20M =
    DIV_W'((PER_20M_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  typedef enum logic [1:0] {
    IRQ_SEL_NONE,
    IRQ_SEL_ZERO,
    IRQ_SEL_ONE
  } irq_sel_e;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } ahb_req_s;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } ahb_rsp_s;

  typedef struct packed {
    logic [NUM_CH-1:0] diff_a;
    logic [NUM_CH-1:0] diff_b;
    logic [NUM_CH-1:0] se_a;
    logic [NUM_CH-1:0] se_b;
  } enc_pins_s;

  typedef struct packed {
    logic              laser_irq_connect_strap;
    logic              laser_gate_mode_strap;
    logic              irq_sel_pins12;
    logic              irq_sel_pins23;
    logic [NUM_CH-1:0] format_strap;
    logic              global_count_dir_strap;
    logic [NUM_CH-1:0] a_source_strap;
    logic [NUM_CH-1:0] b_source_strap;
    logic [2:0]        sample_rate_strap;
  } strap_s;

endpackage : enc_gate_pkg

/* hw/enc_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module enc_counter (
  input  wire logic                            clk,
  input  wire logic                            nrst,
  input  wire logic                            sample_en,
  input  wire logic                            fmt_quad,
  input  wire logic                            invert,
  input  wire logic                            clear,
  input  wire logic                            in_a,
  input  wire logic                            in_b,
  output logic [enc_gate_pkg::CNT_W-1:0]       count,
  output logic                                 wrap
);
  import enc_gate_pkg::*;

  typedef struct packed {
    logic             a_q;
    logic             b_q;
    logic             primed;
    logic [CNT_W-1:0] count;
    logic             wrap;
  } cnt_state_s;

  cnt_state_s r_reg;
  cnt_state_s r_next;

  always_comb begin
    logic step;
    logic up;
    step = 1'b0;
    up = 1'b0;
    r_next = r_reg;
    r_next.wrap = 1'b0;
    if (sample_en) begin
      r_next.a_q = in_a;
      r_next.b_q = in_b;
      r_next.primed = 1'b1;
      // No count on the first sample: history unknown after reset
      if (r_reg.primed) begin
        if (fmt_quad) begin
          // Every single-phase edge counts; a double change is skipped
          if ((in_a ^ r_reg.a_q) ^ (in_b ^ r_reg.b_q)) begin
            step = 1'b1;
            up = in_a ^ r_reg.b_q;
          end
        end else if (in_a && !r_reg.a_q) begin
          step = 1'b1;
          up = in_b;
        end
      end
    end
    up = up ^ invert;
    if (clear) begin
      r_next.count = '0;
    end else if (step && up) begin
      r_next.count = r_reg.count + CNT_W'(1);
      r_next.wrap = &r_reg.count;
    end else if (step) begin
      r_next.count = r_reg.count - CNT_W'(1);
      r_next.wrap = ~|r_reg.count;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign count = r_reg.count;
  assign wrap = r_reg.wrap;

endmodule : enc_counter
`default_nettype wire

/* hw/enc_gate_top.sv */
// Behaviour
// - With the interrupt-connect strap fitted the laser enable input drives the processor interrupt, otherwise that interrupt stays idle.
// - In gate mode one a low laser enable input is active and permits the laser output, otherwise the output stays inactive.
// - In gate mode zero the laser enable input is ignored, in gate mode one the laser fires only while it is low.
// - Interrupt requests go to the base board on two request outputs, both active high.
// - A three-way strap steers requests to line zero, line one or, by default, to neither.
// - Four independent encoder counters exist, each with A and B inputs and its own format strap.
// - A fitted format strap decodes A and B as quadrature, a removed one takes A as count clock and B as direction.
// - One global direction strap, fitted by default, gives standard direction and when removed inverts all channels.
// - Each A and B input is taken from the differential connector in strap position one or the single-ended one otherwise.
// - Quadrature inputs are sampled and every single-phase edge counts, four counts per cycle; a double change between two samples is skipped.
// - The sampling clock is selectable among 2.5, 5, 10 and 20 MHz or a processor clock, and bounds the input rate.
`timescale 1ns/1ps
`default_nettype none
module enc_gate_top (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire enc_gate_pkg::ahb_req_s  ahb_req,
  output logic [31:0]                  hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire enc_gate_pkg::strap_s    straps,
  input  wire enc_gate_pkg::enc_pins_s enc_pins,
  input  wire logic                    laser_enable_in_n,
  input  wire logic                    proc_sample_clk,
  output logic                         laser_out,
  output logic                         laser_irq_to_proc_n,
  output logic                         base_irq_req_zero,
  output logic                         base_irq_req_one,
  output logic                         irq
);
  import enc_gate_pkg::*;

  typedef struct packed {
    logic              arm;
    logic [NUM_CH-1:0] clr;
    logic [NUM_EV-1:0] status;
    logic [NUM_EV-1:0] mask;
    logic              dp_wr;
    logic [7:0]        dp_addr;
    logic              laser_enable_in_q;
    logic              pclk_q;
    logic [DIV_W-1:0]  div;
    logic              samp;
    ahb_rsp_s          rsp;
    logic              laser_out;
    logic              proc_irq_n;
    logic              base0;
    logic              base1;
    logic              irq;
  } top_state_s;

  top_state_s r_reg;
  top_state_s r_next;

  logic [NUM_CH-1:0] sel_a;
  logic [NUM_CH-1:0] sel_b;
  logic [NUM_CH-1:0] wrap;
  logic [CNT_W-1:0]  count [NUM_CH];

  // Strap high is position one (differential), low the single-ended port
  function automatic logic src_pick(input logic strap,
                                    input logic diff_in,
                                    input logic se_in);
    src_pick = strap ? diff_in : se_in;
  endfunction : src_pick

  function automatic irq_sel_e irq_sel_decode(input logic p12,
                                              input logic p23);
    // Both positions at once is treated as no selection
    if (p12 && !p23) begin
      irq_sel_decode = IRQ_SEL_ZERO;
    end else if (p23 && !p12) begin
      irq_sel_decode = IRQ_SEL_ONE;
    end else begin
      irq_sel_decode = IRQ_SEL_NONE;
    end
  endfunction : irq_sel_decode

  function automatic logic [DIV_W-1:0] rate_div(input logic [2:0] code);
    case (code)
      RATE_2M5: rate_div = DIV_2M5;
      RATE_5M:  rate_div = DIV_5M;
      RATE_10M: rate_div = DIV_10M;
      RATE_20M: rate_div = DIV_20M;
      default:  rate_div = '0;
    endcase
  endfunction : rate_div

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      assign sel_a[gi] = src_pick(straps.a_source_strap[gi],
                                  enc_pins.diff_a[gi],
                                  enc_pins.se_a[gi]);
      assign sel_b[gi] = src_pick(straps.b_source_strap[gi],
                                  enc_pins.diff_b[gi],
                                  enc_pins.se_b[gi]);
      enc_counter u_cnt (
        .clk       (clk),
        .nrst      (nrst),
        .sample_en (r_reg.samp),
        .fmt_quad  (straps.format_strap[gi]),
        .invert    (~straps.global_count_dir_strap),
        .clear     (r_reg.clr[gi]),
        .in_a      (sel_a[gi]),
        .in_b      (sel_b[gi]),
        .count     (count[gi]),
        .wrap      (wrap[gi])
      );
    end
  endgenerate

  always_comb begin
    logic              take;
    logic              permit;
    logic [NUM_EV-1:0] ev;
    logic [DIV_W-1:0]  lim;
    logic [31:0]       rd;
    logic [31:0]       sr;
    irq_sel_e          sel;
    take = 1'b0;
    permit = 1'b0;
    ev = '0;
    lim = '0;
    rd = '0;
    sr = '0;
    sel = IRQ_SEL_NONE;
    r_next = r_reg;
    r_next.clr = '0;

    // Sample tick; the tick rate caps the encoder edge rate
    lim = rate_div(straps.sample_rate_strap);
    r_next.pclk_q = proc_sample_clk;
    if (lim == '0) begin
      r_next.div = '0;
      r_next.samp = proc_sample_clk & ~r_reg.pclk_q;
    end else if (r_reg.div >= lim - DIV_W'(1)) begin
      r_next.div = '0;
      r_next.samp = 1'b1;
    end else begin
      r_next.div = r_reg.div + DIV_W'(1);
      r_next.samp = 1'b0;
    end

    // Laser gate
    r_next.laser_enable_in_q = laser_enable_in_n;
    if (straps.laser_gate_mode_strap) begin
      permit = ~laser_enable_in_n;
    end else begin
      permit = 1'b1;
    end
    r_next.laser_out = r_reg.arm & permit;
    if (straps.laser_irq_connect_strap) begin
      r_next.proc_irq_n = laser_enable_in_n;
    end else begin
      r_next.proc_irq_n = 1'b1;
    end

    // Events
    ev[EV_LAS_ON] = r_reg.laser_enable_in_q & ~laser_enable_in_n;
    ev[EV_LAS_OFF] = ~r_reg.laser_enable_in_q & laser_enable_in_n;
    ev[EV_WRAP_LSB +: NUM_CH] = wrap;

    // Data phase of a write taken in the previous cycle
    if (r_reg.dp_wr) begin
      case (r_reg.dp_addr)
        OFS_CTRL: begin
          r_next.arm = ahb_req.hwdata[CTRL_ARM_BIT];
          r_next.clr = ahb_req.hwdata[CTRL_CLR_LSB +: NUM_CH];
        end
        OFS_STATUS: begin
          r_next.status = r_reg.status & ~ahb_req.hwdata[NUM_EV-1:0];
        end
        OFS_MASK: begin
          r_next.mask = ahb_req.hwdata[NUM_EV-1:0];
        end
        default: begin
          r_next.arm = r_reg.arm;
        end
      endcase
    end
    // Setting after clearing lets a same-cycle event survive
    r_next.status = r_next.status | ev;

    // Interrupt steering
    r_next.irq = |(r_next.status & r_next.mask);
    sel = irq_sel_decode(straps.irq_sel_pins12, straps.irq_sel_pins23);
    r_next.base0 = (sel == IRQ_SEL_ZERO) & r_next.irq;
    r_next.base1 = (sel == IRQ_SEL_ONE) & r_next.irq;

    // Strap readback
    sr[SR_CONNECT] = straps.laser_irq_connect_strap;
    sr[SR_GATE] = straps.laser_gate_mode_strap;
    sr[SR_SEL_LSB +: 2] = sel;
    sr[SR_FMT_LSB +: NUM_CH] = straps.format_strap;
    sr[SR_DIR] = straps.global_count_dir_strap;
    sr[SR_SRCA_LSB +: NUM_CH] = straps.a_source_strap;
    sr[SR_SRCB_LSB +: NUM_CH] = straps.b_source_strap;
    sr[SR_RATE_LSB +: 3] = straps.sample_rate_strap;

    // Address phase; read data uses next control, status and mask values so a write to them is seen at once
    take = ahb_req.hsel & ahb_req.htrans[HTRANS_ACTIVE_BIT]
           & ahb_req.hready;
    r_next.dp_wr = take & ahb_req.hwrite;
    r_next.dp_addr = ahb_req.haddr[7:0];
    case (ahb_req.haddr[7:0])
      OFS_CTRL: begin
        rd[CTRL_ARM_BIT] = r_next.arm;
      end
      OFS_STATUS: rd[NUM_EV-1:0] = r_next.status;
      OFS_MASK:   rd[NUM_EV-1:0] = r_next.mask;
      OFS_STRAPS: rd = sr;
      OFS_COUNT0: rd = count[0];
      OFS_COUNT1: rd = count[1];
      OFS_COUNT2: rd = count[2];
      OFS_COUNT3: rd = count[3];
      default:    rd = '0;
    endcase
    if (take && !ahb_req.hwrite) begin
      r_next.rsp.hrdata = rd;
    end else begin
      r_next.rsp.hrdata = '0;
    end
    r_next.rsp.hreadyout = 1'b1;
    r_next.rsp.hresp = HRESP_OKAY;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
      r_reg.arm <= CTRL_ARM_RST;
      r_reg.mask <= MASK_RST;
      r_reg.laser_enable_in_q <= 1'b1;
      r_reg.proc_irq_n <= 1'b1;
      r_reg.rsp.hreadyout <= 1'b1;
      r_reg.rsp.hresp <= HRESP_OKAY;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hrdata = r_reg.rsp.hrdata;
  assign hreadyout = r_reg.rsp.hreadyout;
  assign hresp = r_reg.rsp.hresp;
  assign laser_out = r_reg.laser_out;
  assign laser_irq_to_proc_n = r_reg.proc_irq_n;
  assign base_irq_req_zero = r_reg.base0;
  assign base_irq_req_one = r_reg.base1;
  assign irq = r_reg.irq;

endmodule : enc_gate_top
`default_nettype wire

/* sim/enc_gate_props.sv */
`timescale 1ns/1ps
`default_nettype none
module enc_gate_props (
  input wire logic                   clk,
  input wire logic                   nrst,
  input wire enc_gate_pkg::ahb_req_s ahb_req,
  input wire logic [31:0]            hrdata,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire enc_gate_pkg::strap_s   straps,
  input wire logic                   laser_enable_in_n,
  input wire logic                   laser_out,
  input wire logic                   laser_irq_to_proc_n,
  input wire logic                   base_irq_req_zero,
  input wire logic                   base_irq_req_one,
  input wire logic                   irq
);
  import enc_gate_pkg::*;
  wire logic sel_zero = straps.irq_sel_pins12 & ~straps.irq_sel_pins23;
  wire logic sel_one = straps.irq_sel_pins23 & ~straps.irq_sel_pins12;
  wire logic rd_taken = ahb_req.hsel & ahb_req.htrans[1] &
                        ahb_req.hready & ~ahb_req.hwrite;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Both cycles needed: the line is registered with irq but takes the strap select one register late
  sequence s_irq_zero; (irq && sel_zero) [*2]; endsequence
  sequence s_irq_one; (irq && sel_one) [*2]; endsequence

  a_irq_connect: assert property ($past(nrst) |->
    laser_irq_to_proc_n == ($past(straps.laser_irq_connect_strap) ?
    $past(laser_enable_in_n) : 1'b1))
    else $error("proc interrupt does not follow strap");
  a_gate_block: assert property ($past(nrst) &&
    $past(straps.laser_gate_mode_strap) && $past(laser_enable_in_n)
    |-> !laser_out) else $error("laser fired without enable");
  a_zero_only: assert property ($past(nrst) && !$past(sel_zero)
    |-> !base_irq_req_zero) else $error("line zero not selected");
  a_one_only: assert property ($past(nrst) && !$past(sel_one)
    |-> !base_irq_req_one) else $error("line one not selected");
  a_never_both: assert property (!(base_irq_req_zero &&
    base_irq_req_one)) else $error("both request lines high");
  a_zero_follow: assert property (s_irq_zero |-> base_irq_req_zero)
    else $error("line zero missed request");
  a_one_follow: assert property (s_irq_one |-> base_irq_req_one)
    else $error("line one missed request");
  a_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY)
    else $error("bus not ready or not okay");
  a_read_idle: assert property ($past(nrst) && !$past(rd_taken)
    |-> hrdata == 32'h0) else $error("read data outside data phase");
endmodule : enc_gate_props

bind enc_gate_top enc_gate_props i_props (.clk(clk), .nrst(nrst),
  .ahb_req(ahb_req), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .straps(straps), .laser_enable_in_n(laser_enable_in_n),
  .laser_out(laser_out), .laser_irq_to_proc_n(laser_irq_to_proc_n),
  .base_irq_req_zero(base_irq_req_zero),
  .base_irq_req_one(base_irq_req_one), .irq(irq));
`default_nettype wire

/* sim/enc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module enc_model (
  input wire logic                  clk,
  input wire enc_gate_pkg::strap_s  straps,
  output var enc_gate_pkg::enc_pins_s pins
);
  import enc_gate_pkg::*;
  // Steps far slower than a tick so no edge is lost
  localparam int HOLD = 20;
  logic [NUM_CH-1:0] a_lvl = '0;
  logic [NUM_CH-1:0] b_lvl = '0;
  // Unused connector shows the inverse so a wrong pick of B, or of A in quadrature, counts backwards
  always_comb begin
    pins.diff_a = a_lvl ^ ~straps.a_source_strap;
    pins.se_a = a_lvl ^ straps.a_source_strap;
    pins.diff_b = b_lvl ^ ~straps.b_source_strap;
    pins.se_b = b_lvl ^ straps.b_source_strap;
  end
  task automatic quad(input int ch, input logic up, input int n);
    repeat (n) begin
      @(posedge clk);
      if ((a_lvl[ch] == b_lvl[ch]) == up) a_lvl[ch] <= ~a_lvl[ch];
      else b_lvl[ch] <= ~b_lvl[ch];
      repeat (HOLD) @(posedge clk);
    end
  endtask : quad
  task automatic pulse(input int ch, input logic dir);
    @(posedge clk);
    b_lvl[ch] <= dir;
    repeat (HOLD) @(posedge clk);
    a_lvl[ch] <= 1'b1;
    repeat (HOLD) @(posedge clk);
    a_lvl[ch] <= 1'b0;
    repeat (HOLD) @(posedge clk);
  endtask : pulse
endmodule : enc_model
`default_nettype wire

/* sim/encoder_input_and_laser_gate_config_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module encoder_input_and_laser_gate_config_test;
  import enc_gate_pkg::*;
  logic clk, nrst, las_n, hreadyout, hresp, laser_out, proc_n;
  logic irq_z, irq_o, irq, pclk;
  logic [31:0] hrdata;
  int bad_count, num_checks;
  ahb_req_s bus_q, ahb_req;
  strap_s straps;
  enc_pins_s pins;
  always_comb begin
    ahb_req = bus_q;
    ahb_req.hready = hreadyout;
  end
  enc_gate_top i_dut (.clk(clk), .nrst(nrst), .ahb_req(ahb_req),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .straps(straps), .enc_pins(pins), .laser_enable_in_n(las_n),
    .proc_sample_clk(pclk), .laser_out(laser_out),
    .laser_irq_to_proc_n(proc_n), .base_irq_req_zero(irq_z),
    .base_irq_req_one(irq_o), .irq(irq));
  enc_model i_enc (.clk(clk), .straps(straps), .pins(pins));

  task automatic summarize();
    if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic bus(input logic wr, input logic [7:0] ofs,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    bus_q.hsel <= 1'b1;
    bus_q.haddr <= {24'h0, ofs};
    bus_q.htrans <= 2'b10;
    bus_q.hwrite <= wr;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    bus_q.hsel <= 1'b0;
    bus_q.htrans <= 2'b00;
    bus_q.hwdata <= wd;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) begin bad_count++; summarize(); end
  endtask : bus
  task automatic set_in(input logic v);
    las_n <= v;
    cyc(3);
  endtask : set_in

  task automatic t_regs();
    logic [31:0] d;
    bus(0, OFS_STRAPS, 0, d);
    `CHK(d, {12'h0, 3'h3, 4'b0101, 4'b0011, 1'b1, 4'b0101, 4'b0011});
    bus(0, OFS_CTRL, 0, d);
    `CHK(d, 32'h0);
    bus(1, 8'h20, 32'hffff_ffff, d);
    bus(0, 8'h20, 0, d);
    `CHK(d, 32'h0);
    bus(1, OFS_MASK, 32'h3f, d);
    bus(0, OFS_MASK, 0, d);
    `CHK(d, 32'h3f);
  endtask : t_regs
  task automatic t_laser();
    logic [31:0] d;
    bus(1, OFS_CTRL, 32'h1, d);
    set_in(1'b0);
    `CHK({laser_out, proc_n}, 2'b10);
    set_in(1'b1);
    `CHK({laser_out, proc_n}, 2'b01);
    straps.laser_gate_mode_strap <= 1'b0;
    cyc(3);
    `CHK(laser_out, 1'b1);
    straps.laser_irq_connect_strap <= 1'b0;
    set_in(1'b0);
    `CHK({laser_out, proc_n}, 2'b11);
    bus(1, OFS_CTRL, 32'h0, d);
    cyc(2);
    `CHK(laser_out, 1'b0);
    straps.laser_gate_mode_strap <= 1'b1;
    straps.laser_irq_connect_strap <= 1'b1;
    set_in(1'b1);
  endtask : t_laser
  task automatic t_irq();
    logic [31:0] d;
    logic [1:0] s;
    bus(1, OFS_STATUS, 32'h3f, d);
    bus(1, OFS_MASK, 32'h1, d);
    set_in(1'b0);
    `CHK(irq, 1'b1);
    for (int i = 0; i < 4; i++) begin
      s = 2'(i);
      {straps.irq_sel_pins12, straps.irq_sel_pins23} <= s;
      cyc(3);
      `CHK({irq_z, irq_o}, (s == 2'b11) ? 2'b00 : s);
    end
    straps.irq_sel_pins23 <= 1'b0;
    bus(1, OFS_STATUS, 32'h1, d);
    cyc(3);
    `CHK({irq, irq_z}, 2'b00);
    set_in(1'b1);
    bus(0, OFS_STATUS, 0, d);
    `CHK({d[5:0], irq, irq_z}, 8'h08);
    straps.irq_sel_pins12 <= 1'b0;
  endtask : t_irq
  // Formats stay fixed for the whole run; only counters are cleared
  task automatic t_quad();
    logic [31:0] d;
    for (int c = 0; c < 4; c += 2) begin
      bus(1, OFS_CTRL, 32'h1e, d);
      i_enc.quad(c, 1'b1, 6);
      straps.global_count_dir_strap <= 1'b0;
      i_enc.quad(c, 1'b1, 2);
      straps.global_count_dir_strap <= 1'b1;
      bus(0, OFS_COUNT0 + 8'(4 * c), 0, d);
      `CHK(d, 32'd4);
      bus(0, OFS_COUNT0 + 8'(4 * c + 4), 0, d);
      `CHK(d, 32'd0);
    end
  endtask : t_quad
  task automatic t_cdir();
    logic [31:0] d;
    for (int c = 1; c < 4; c += 2) begin
      bus(1, OFS_CTRL, 32'h1e, d);
      bus(1, OFS_STATUS, 32'h3f, d);
      i_enc.pulse(c, 1'b0);
      bus(0, OFS_COUNT0 + 8'(4 * c), 0, d);
      `CHK(d, 32'hffff_ffff);
      bus(0, OFS_STATUS, 0, d);
      `CHK(d[EV_WRAP_LSB + c], 1'b1);
      repeat (3) i_enc.pulse(c, 1'b1);
      straps.global_count_dir_strap <= 1'b0;
      i_enc.pulse(c, 1'b1);
      straps.global_count_dir_strap <= 1'b1;
      bus(0, OFS_COUNT0 + 8'(4 * c), 0, d);
      `CHK(d, 32'd1);
    end
  endtask : t_cdir
  // Processor clock as tick source: no edge on it, no count
  task automatic t_rate();
    logic [31:0] d;
    bus(1, OFS_CTRL, 32'h1e, d);
    straps.sample_rate_strap <= 3'h4;
    i_enc.pulse(1, 1'b1);
    bus(0, OFS_COUNT1, 0, d);
    `CHK(d, 32'd0);
    fork
      i_enc.pulse(1, 1'b1);
      repeat (32) begin
        cyc(2);
        pclk <= ~pclk;
      end
    join
    bus(0, OFS_COUNT1, 0, d);
    `CHK(d, 32'd1);
    straps.sample_rate_strap <= 3'h3;
  endtask : t_rate

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #100000;
    bad_count++;
    summarize();
  end
  initial begin
    nrst = 1'b0;
    las_n = 1'b1;
    pclk = 1'b0;
    bus_q = '0;
    bus_q.hsize = 3'h2;
    // Format straps settle before reset ends and never change
    straps = '{1'b1, 1'b1, 1'b0, 1'b0, 4'b0101, 1'b1, 4'b0011, 4'b0101,
               3'h3};
    cyc(4);
    nrst <= 1'b1;
    cyc(2);
    t_regs();
    t_laser();
    t_irq();
    t_quad();
    t_cdir();
    t_rate();
    summarize();
  end
endmodule : encoder_input_and_laser_gate_config_test
`default_nettype wire
